//--- src/spmon_pkg.sv
// package for the signal peak monitor: register map, fields, reset values
// assumes an APB slave with 32-bit data, one register per aligned word
package spmon_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] SPMON_IDX_SYNC_CTRL = 12'h26F;
    localparam logic [11:0] SPMON_IDX_CTRL = 12'h270;
    localparam logic [11:0] SPMON_IDX_PERIOD0 = 12'h271;
    localparam logic [11:0] SPMON_IDX_PERIOD1 = 12'h272;
    localparam logic [11:0] SPMON_IDX_PERIOD2 = 12'h273;
    localparam logic [11:0] SPMON_IDX_RES_CTRL = 12'h274;
    localparam logic [11:0] SPMON_IDX_RESULT0 = 12'h275;
    localparam logic [11:0] SPMON_IDX_RESULT1 = 12'h276;
    localparam logic [11:0] SPMON_IDX_RESULT2 = 12'h277;
    localparam logic [11:0] SPMON_IDX_PCOUNT = 12'h278;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int SPMON_BIT_PEAK_EN = 1;
    localparam int SPMON_BIT_UPDATE = 4;
    localparam int SPMON_BIT_RES_SEL = 0;
    localparam logic [7:0] SPMON_RST_SYNC = 8'h00;
    localparam logic [7:0] SPMON_RST_CTRL = 8'h00;
    localparam logic [7:0] SPMON_RST_PERIOD0 = 8'h80;
    localparam logic [7:0] SPMON_RST_PERIOD1 = 8'h00;
    localparam logic [7:0] SPMON_RST_PERIOD2 = 8'h00;
    localparam logic [7:0] SPMON_RST_RES_CTRL = 8'h01;
    localparam int SPMON_SAMPLE_W = 14;
    localparam int SPMON_PEAK_W = 13;
    localparam int SPMON_RESULT_W = 20;
    localparam int SPMON_PAD_W = 7;

    // synchronization modes
    typedef enum logic [1:0] {
        SPMON_SYNC_OFF = 2'b00,
        SPMON_SYNC_CONT = 2'b01,
        SPMON_SYNC_RSVD = 2'b10,
        SPMON_SYNC_ONCE = 2'b11
    } spmon_sync_mode_t;

    // one sample from the converter path
    typedef struct packed {
        logic valid;
        logic signed [13:0] data;
    } spmon_sample_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } spmon_apb_req_t;

endpackage : spmon_pkg

//--- src/spmon_sync2.sv
// two-flop synchroniser for a level from outside the pclk domain
// assumes pclk free-running
`timescale 1ns/100ps
module spmon_sync2
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level in and out
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;

    // first flop only feeds the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : spmon_sync2

//--- src/spmon_peak_core.sv
// peak hold and period counter of the signal peak monitor
// assumes samples arrive on pclk with a valid strobe (decimated clock)
`timescale 1ns/100ps
module spmon_peak_core
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic restart,
    input wire logic [23:0] period,
    input wire spmon_pkg::spmon_sample_t sample,
    // state
    output logic [12:0] peak_q,
    output logic [23:0] count_q
);
    import spmon_pkg::*;

    logic [13:0] mag;
    logic [12:0] mag_sat;
    logic expire;

    // absolute value, saturating the most negative code
    always_comb
    begin
        mag = sample.data[13] ? 14'(-sample.data) : 14'(sample.data);
        mag_sat = mag[13] ? 13'h1FFF : mag[12:0];
    end

    assign expire = sample.valid && (count_q + 24'h000001 >= period);

    // period counter in decimated output cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= 24'h000000;
        else if (!enable || restart || expire)
            count_q <= 24'h000000;
        else if (sample.valid)
            count_q <= count_q + 24'h000001;
    end

    // largest magnitude within the current period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            peak_q <= 13'h0000;
        else if (!enable)
            peak_q <= 13'h0000;
        else if (restart || expire)
            peak_q <= sample.valid ? mag_sat : 13'h0000;
        else if (sample.valid && mag_sat > peak_q)
            peak_q <= mag_sat;
    end

    a_peak_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> peak_q == 13'h0000) else $error("peak not cleared while off");
    a_peak_grows: assert property (@(posedge pclk) disable iff (!presetn)
        enable && !restart && !expire && sample.valid && mag_sat > peak_q
        |=> peak_q == $past(mag_sat)) else $error("peak missed a larger sample");
endmodule : spmon_peak_core

//--- src/spmon_top.sv
// apb register block and control of the signal peak monitor
// assumes apb master on pclk, sample stream on pclk, sync pin asynchronous
`timescale 1ns/100ps

module spmon_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter samples and external sync
    input wire spmon_pkg::spmon_sample_t sample,
    input wire logic sync_pin
);
    import spmon_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    spmon_apb_req_t req;
    logic [7:0] sync_ctrl_q;
    logic [7:0] ctrl_q;
    logic [7:0] period0_q;
    logic [7:0] period1_q;
    logic [7:0] period2_q;
    logic res_sel_q;
    logic update_q;
    logic [19:0] result_q;
    logic [7:0] pcount_q;
    logic [12:0] peak;
    logic [23:0] count;
    logic sync_s;
    logic sync_prev_q;
    logic sync_edge;
    logic once_done_q;
    logic restart;
    logic [11:0] idx;
    logic mapped;
    logic wr;
    logic [7:0] rdata_d;
    logic rd_setup;
    spmon_sync_mode_t mode;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
        pwdata: pwdata};
    assign idx = req.paddr[13:2];
    assign mode = spmon_sync_mode_t'(sync_ctrl_q[1:0]);

    // ------------------------------------------------------------
    // apb handshake: zero wait states
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign wr = req.psel && req.penable && req.pwrite && pstrb[0];

    // decode of mapped words
    always_comb
    begin
        mapped = (idx >= SPMON_IDX_SYNC_CTRL) && (idx <= SPMON_IDX_PCOUNT)
            && (req.paddr[1:0] == 2'b00) && (req.paddr[31:14] == 18'h00000);
    end

    assign pslverr = req.psel && req.penable && !mapped;

    // ------------------------------------------------------------
    // external sync
    // ------------------------------------------------------------
    spmon_sync2 u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_i(sync_pin),
        .sync_o(sync_s)
    );

    // rising edge of the synchronised sync level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_prev_q <= 1'b0;
        else
            sync_prev_q <= sync_s;
    end

    assign sync_edge = sync_s && !sync_prev_q;

    // mode decides which sync events restart the monitor
    always_comb
    begin
        case (mode)
            SPMON_SYNC_CONT: restart = sync_edge;
            SPMON_SYNC_ONCE: restart = sync_edge && !once_done_q;
            SPMON_SYNC_OFF: restart = 1'b0;
            default: restart = 1'b0;
        endcase
    end

    // one-shot arming, rearmed by leaving one-shot mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            once_done_q <= 1'b0;
        else if (mode != SPMON_SYNC_ONCE)
            once_done_q <= 1'b0;
        else if (sync_edge)
            once_done_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // sync control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_ctrl_q <= SPMON_RST_SYNC;
        else if (wr && idx == SPMON_IDX_SYNC_CTRL)
            sync_ctrl_q <= {6'h00, req.pwdata[1:0]};
    end

    // monitor control, only the enable bit is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= SPMON_RST_CTRL;
        else if (wr && idx == SPMON_IDX_CTRL)
            ctrl_q <= {6'h00, req.pwdata[SPMON_BIT_PEAK_EN], 1'b0};
    end

    // period bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period0_q <= SPMON_RST_PERIOD0;
            period1_q <= SPMON_RST_PERIOD1;
            period2_q <= SPMON_RST_PERIOD2;
        end
        else if (wr)
        begin
            if (idx == SPMON_IDX_PERIOD0)
                period0_q <= req.pwdata[7:0];
            if (idx == SPMON_IDX_PERIOD1)
                period1_q <= req.pwdata[7:0];
            if (idx == SPMON_IDX_PERIOD2)
                period2_q <= req.pwdata[7:0];
        end
    end

    // result selection bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            res_sel_q <= SPMON_RST_RES_CTRL[SPMON_BIT_RES_SEL];
        else if (wr && idx == SPMON_IDX_RES_CTRL)
            res_sel_q <= req.pwdata[SPMON_BIT_RES_SEL];
    end

    // update request, cleared by hardware one cycle after the write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            update_q <= 1'b0;
        else if (wr && idx == SPMON_IDX_RES_CTRL)
            update_q <= req.pwdata[SPMON_BIT_UPDATE];
        else
            update_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // peak detector
    // ------------------------------------------------------------
    spmon_peak_core u_core
    (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl_q[SPMON_BIT_PEAK_EN]),
        .restart(restart),
        .period({period2_q, period1_q, period0_q}),
        .sample(sample),
        .peak_q(peak),
        .count_q(count)
    );

    // ------------------------------------------------------------
    // result snapshot
    // ------------------------------------------------------------
    // read-only results change only on an update request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_q <= 20'h00000;
            pcount_q <= 8'h00;
        end
        else if (update_q)
        begin
            if (res_sel_q)
                result_q <= {peak, {SPMON_PAD_W{1'b0}}};
            else
                result_q <= 20'h00000;
            pcount_q <= count[7:0];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read mux, writes to result words have no effect
    always_comb
    begin
        case (idx)
            SPMON_IDX_SYNC_CTRL: rdata_d = sync_ctrl_q;
            SPMON_IDX_CTRL: rdata_d = ctrl_q;
            SPMON_IDX_PERIOD0: rdata_d = period0_q;
            SPMON_IDX_PERIOD1: rdata_d = period1_q;
            SPMON_IDX_PERIOD2: rdata_d = period2_q;
            SPMON_IDX_RES_CTRL: rdata_d = {3'h0, update_q, 3'h0, res_sel_q};
            SPMON_IDX_RESULT0: rdata_d = result_q[7:0];
            SPMON_IDX_RESULT1: rdata_d = result_q[15:8];
            SPMON_IDX_RESULT2: rdata_d = {4'h0, result_q[19:16]};
            SPMON_IDX_PCOUNT: rdata_d = pcount_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // read setup cycle: the one cycle in which read data is captured
    assign rd_setup = req.psel && !req.penable && !req.pwrite;

    // registered read data, loaded in the setup cycle so it stands in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= mapped ? {24'h000000, rdata_d} : 32'h00000000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // update strobe and result snapshot
    a_update_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
        update_q |=> !update_q || $past(wr && idx == SPMON_IDX_RES_CTRL))
        else $error("update bit did not clear");
    a_update_visible: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && mapped && idx == SPMON_IDX_RES_CTRL
        |=> prdata[SPMON_BIT_UPDATE] == $past(update_q))
        else $error("pending update bit not readable");
    a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !update_q |=> $stable(result_q) && $stable(pcount_q))
        else $error("result changed without update");
    a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
        update_q && res_sel_q |=> result_q == {$past(peak), {SPMON_PAD_W{1'b0}}})
        else $error("snapshot does not match peak");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        update_q && !res_sel_q |=> result_q == 20'h00000)
        else $error("reserved selection did not report zero");
    a_low_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        result_q[6:0] == 7'h00) else $error("result low bits not zero");
    a_pcount_load: assert property (@(posedge pclk) disable iff (!presetn)
        update_q |=> pcount_q == $past(count[7:0]))
        else $error("period count snapshot wrong");

    // result words read back the snapshot, never the live values
    a_result_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && mapped && idx == SPMON_IDX_RESULT0
        |=> prdata[7:0] == $past(result_q[7:0]))
        else $error("result word does not read the snapshot");
    a_pcount_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && mapped && idx == SPMON_IDX_PCOUNT
        |=> prdata[7:0] == $past(pcount_q))
        else $error("period count word does not read the snapshot");
    a_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx >= SPMON_IDX_RESULT0 |=> $stable(result_q) || $past(update_q))
        else $error("write changed a result word");

    // synchronization modes
    a_sync_off: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SPMON_SYNC_OFF |-> !restart) else $error("restart while sync off");
    a_sync_cont: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SPMON_SYNC_CONT && sync_edge |-> restart)
        else $error("continuous mode missed a sync event");
    a_sync_once: assert property (@(posedge pclk) disable iff (!presetn)
        restart && mode == SPMON_SYNC_ONCE ##1 mode == SPMON_SYNC_ONCE |-> !restart)
        else $error("one-shot restarted twice in a row");
    a_once_spent: assert property (@(posedge pclk) disable iff (!presetn)
        mode == SPMON_SYNC_ONCE && once_done_q |-> !restart)
        else $error("one-shot mode restarted after its first event");

    // register writes land in the access cycle
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == SPMON_IDX_CTRL
        |=> ctrl_q[SPMON_BIT_PEAK_EN] == $past(req.pwdata[SPMON_BIT_PEAK_EN]))
        else $error("enable bit not written");
    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == SPMON_IDX_RES_CTRL |=> res_sel_q == $past(req.pwdata[SPMON_BIT_RES_SEL]))
        else $error("select bit not written");
    a_period_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == SPMON_IDX_PERIOD0 |=> period0_q == $past(req.pwdata[7:0]))
        else $error("period byte not written");
    a_period_upper: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == SPMON_IDX_PERIOD2 |=> period2_q == $past(req.pwdata[7:0]))
        else $error("upper period byte not written");
    a_strobe_gate: assert property (@(posedge pclk) disable iff (!presetn)
        req.psel && req.penable && req.pwrite && !pstrb[0]
        |=> $stable(period0_q) && $stable(ctrl_q) && $stable(sync_ctrl_q))
        else $error("write without byte strobe took effect");

    // detector off and period expiry
    a_disabled_count: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[SPMON_BIT_PEAK_EN] |=> count == 24'h000000 && peak == 13'h0000)
        else $error("detector running while disabled");
    a_period_expire: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[SPMON_BIT_PEAK_EN] && sample.valid
        && (count + 24'h000001 >= {period2_q, period1_q, period0_q}) |=> count == 24'h000000)
        else $error("period counter did not restart on expiry");

    // main scenarios
    c_update: cover property (@(posedge pclk) disable iff (!presetn) update_q && res_sel_q);
    c_sync_cont: cover property (@(posedge pclk) disable iff (!presetn)
        restart && mode == SPMON_SYNC_CONT);
    c_sync_once: cover property (@(posedge pclk) disable iff (!presetn)
        restart && mode == SPMON_SYNC_ONCE);
    c_once_spent: cover property (@(posedge pclk) disable iff (!presetn)
        mode == SPMON_SYNC_ONCE && once_done_q && sync_edge);
    c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : spmon_top

//--- testbench/signal_peak_monitor_bench.sv
// bench for the signal peak monitor: apb register traffic, samples and sync pulses
// assumes spmon_pkg and spmon_top compiled first; assertions live in the design files
`timescale 1ns/100ps
module signal_peak_monitor_bench;
    import spmon_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    spmon_sample_t sample = '0;
    logic sync_pin = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic [23:0] rd_hi;
    logic err;
    logic [1:0] modes [4] = '{2'b01, 2'b11, 2'b00, 2'b10};
    logic [12:0] exp1 [4] = '{13'h0, 13'h0, 13'd50, 13'd50};
    logic [12:0] exp2 [4] = '{13'h0, 13'd40, 13'd50, 13'd50};

    // 8 ns clock
    always #4 pclk = ~pclk;

    spmon_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample(sample), .sync_pin(sync_pin));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer: setup, access until pready, then release
    task apb_xfer(input logic [11:0] idx, input logic wr, input logic [7:0] wd,
                  output logic [7:0] rdat, output logic perr);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {18'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for pready; only the bench timeout ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata[7:0];
        rd_hi = prdata[31:8];
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task wr(input logic [11:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        logic e;
        apb_xfer(idx, 1'b1, wd, d, e);
    endtask : wr

    task chk_reg(input logic [11:0] idx, input logic [7:0] exp);
        apb_xfer(idx, 1'b0, 8'h00, rd, err);
        chk(rd, exp);
        chk({7'h0, err}, 8'h00);
        chk({7'h0, |rd_hi}, 8'h00);
    endtask : chk_reg

    // peak sits in bits 19:7 of the result, low bits zero
    task chk_result(input logic [12:0] mag);
        logic [19:0] r;
        r = {mag, 7'h00};
        chk_reg(SPMON_IDX_RESULT0, r[7:0]);
        chk_reg(SPMON_IDX_RESULT1, r[15:8]);
        chk_reg(SPMON_IDX_RESULT2, {4'h0, r[19:16]});
    endtask : chk_result

    task send(input logic signed [13:0] v);
        @(posedge pclk);
        sample <= '{valid: 1'b1, data: v};
        @(posedge pclk);
        sample.valid <= 1'b0;
    endtask : send

    task pulse_sync;
        @(posedge pclk);
        sync_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        sync_pin <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pulse_sync

    // ------------------------------------------------------------
    // timeout
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        chk_reg(SPMON_IDX_SYNC_CTRL, 8'h00);
        chk_reg(SPMON_IDX_CTRL, 8'h00);
        chk_reg(SPMON_IDX_PERIOD0, 8'h80);
        chk_reg(SPMON_IDX_PERIOD1, 8'h00);
        chk_reg(SPMON_IDX_RES_CTRL, 8'h01);
        chk_result(13'h0);
        chk_reg(SPMON_IDX_PCOUNT, 8'h00);
        apb_xfer(12'h279, 1'b0, 8'h00, rd, err);
        chk(rd, 8'h00);
        chk({7'h0, err}, 8'h01);
        // readback of period bytes, writes to results ignored
        wr(SPMON_IDX_PERIOD0, 8'h12);
        wr(SPMON_IDX_PERIOD1, 8'h34);
        wr(SPMON_IDX_PERIOD2, 8'h56);
        chk_reg(SPMON_IDX_PERIOD0, 8'h12);
        chk_reg(SPMON_IDX_PERIOD1, 8'h34);
        chk_reg(SPMON_IDX_PERIOD2, 8'h56);
        // a write without its byte strobe is dropped
        pstrb <= 4'h0;
        wr(SPMON_IDX_PERIOD0, 8'hAA);
        pstrb <= 4'hF;
        chk_reg(SPMON_IDX_PERIOD0, 8'h12);
        wr(SPMON_IDX_RESULT1, 8'hFF);
        wr(SPMON_IDX_PCOUNT, 8'hFF);
        chk_reg(SPMON_IDX_RESULT1, 8'h00);
        chk_reg(SPMON_IDX_PCOUNT, 8'h00);
        // period of 16 samples, detector on
        wr(SPMON_IDX_PERIOD0, 8'h10);
        wr(SPMON_IDX_PERIOD1, 8'h00);
        wr(SPMON_IDX_PERIOD2, 8'h00);
        wr(SPMON_IDX_CTRL, 8'h02);
        chk_reg(SPMON_IDX_CTRL, 8'h02);
        send(-14'sd5);
        send(14'sd100);
        send(-14'sd300);
        wr(SPMON_IDX_RES_CTRL, 8'h11);
        chk_reg(SPMON_IDX_RES_CTRL, 8'h01);
        chk_result(13'd300);
        chk_reg(SPMON_IDX_PCOUNT, 8'h03);
        // no update, no change
        send(14'sd1000);
        chk_result(13'd300);
        send(-14'sd8192);
        wr(SPMON_IDX_RES_CTRL, 8'h11);
        chk_result(13'h1FFF);
        chk_reg(SPMON_IDX_PCOUNT, 8'h05);
        // fill the period, then one sample in the next
        repeat (11) send(14'sd2);
        send(14'sd7);
        wr(SPMON_IDX_RES_CTRL, 8'h11);
        chk_result(13'd7);
        chk_reg(SPMON_IDX_PCOUNT, 8'h01);
        // reserved selection reports zero
        wr(SPMON_IDX_RES_CTRL, 8'h10);
        chk_result(13'h0);
        wr(SPMON_IDX_RES_CTRL, 8'h01);
        // disabled detector holds zero
        wr(SPMON_IDX_CTRL, 8'h00);
        send(14'sd60);
        wr(SPMON_IDX_RES_CTRL, 8'h11);
        chk_result(13'h0);
        // sync modes, long period
        wr(SPMON_IDX_PERIOD0, 8'h00);
        wr(SPMON_IDX_PERIOD1, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(SPMON_IDX_SYNC_CTRL, {6'h0, modes[i]});
            chk_reg(SPMON_IDX_SYNC_CTRL, {6'h0, modes[i]});
            wr(SPMON_IDX_CTRL, 8'h00);
            wr(SPMON_IDX_CTRL, 8'h02);
            send(14'sd50);
            pulse_sync;
            wr(SPMON_IDX_RES_CTRL, 8'h11);
            chk_result(exp1[i]);
            send(-14'sd40);
            pulse_sync;
            wr(SPMON_IDX_RES_CTRL, 8'h11);
            chk_result(exp2[i]);
        end
        tally_and_finish;
    end
endmodule : signal_peak_monitor_bench
